// >>> logic/ofdr_map.svh
// Register offsets, codes, reset values and timing counts of the frequency detector.
`ifndef OFDR_MAP_SVH
`define OFDR_MAP_SVH
`define OFDR_ADDR_UNLOCK 16'h1F7F
`define OFDR_ADDR_CTRL 16'h1F7C
`define OFDR_ADDR_LOWER 16'h1F7D
`define OFDR_ADDR_UPPER 16'h1F7E
`define OFDR_UNLOCK_OPEN 8'hF9
`define OFDR_UNLOCK_SHUT 8'h06
`define OFDR_CTRL_ON 8'hE4
`define OFDR_CTRL_OFF 8'h00
`define OFDR_LOWER_RST 8'h20
`define OFDR_UPPER_RST 8'h40
`define OFDR_READ_IDLE 8'h00
`define OFDR_CLK_MHZ 250
`define OFDR_WINDOW_NS 3200
`define OFDR_WINDOW_CYC ((`OFDR_WINDOW_NS * `OFDR_CLK_MHZ) / 1000)
`define OFDR_PERSIST_NS 12800
`define OFDR_PERSIST_WIN (`OFDR_PERSIST_NS / `OFDR_WINDOW_NS)
`define OFDR_EDGE_MAX 8'hFF
`endif

// >>> logic/ofdr_pkg.sv
// Types shared by the oscillation frequency detector.
package ofdr_pkg;

	typedef enum logic [1:0] {
		PH_OFF,
		PH_WATCH,
		PH_FAULT
	} ofdr_phase_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ofdr_bus_t;

	typedef struct packed {
		logic normal;
		logic idle;
		logic stop;
		logic warmup;
		logic serial_prog;
		logic internal_reset;
	} ofdr_mode_t;

	typedef struct packed {
		logic [7:0] detect_write_unlock;
		logic [7:0] detect_enable_control;
		logic [7:0] lower_freq_limit;
		logic [7:0] upper_freq_limit;
		logic [7:0] rdata;
		logic osc_prev;
		logic [9:0] win_cnt;
		logic [7:0] edge_cnt;
		logic [2:0] bad_cnt;
		logic [2:0] good_cnt;
		logic det_rst;
		logic active;
		ofdr_phase_t phase;
	} ofdr_state_t;

endpackage

// >>> logic/ofdr_top.sv
// Oscillation frequency detector with write-protected control and limit registers.
//
// Operation
// - Unlocked, E4H enables and 00H disables detection.
// - Unlock value F9H opens, 06H blocks control writes.
// - Control register always readable.
// - External reset loads unlock 06H, control 00H.
// - Unlock and control survive internal resets.
// - Stop pauses detection until warm-up ends.
// - Serial programming mode disables detection.
// - Detection only in normal, idle and internal-reset modes.
// - No detection during external reset.
// - Detection stays active during internal resets.
// - Limits locked while enabled or write-protected.
// - Limits reset to 20H and 40H.
// - Limits survive internal resets, cleared externally only.
// - Out-of-range frequency for persistence time asserts reset.
// - Detector reset puts I/Os in high impedance.
// - Stopped oscillator for persistence time asserts reset.
// - Reset released after in-range persistence time.
//
// Implementation choices: the address-and-strobe port and the register offsets.
module ofdr_top
	import ofdr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire ofdr_pkg::ofdr_bus_t bus,
	input wire ofdr_pkg::ofdr_mode_t mode,
	input wire logic osc_input_pin,
	output logic [7:0] rdata,
	output logic detect_reset,
	output logic io_hiz_req,
	output logic detect_active
);
	import ofdr_pkg::*;
	`include "ofdr_map.svh"

	////////////////////////////////////////////////////////////////////////////////
	// Constants sized to the counters they meet.

	localparam logic [9:0] WIN_LAST = 10'(`OFDR_WINDOW_CYC - 1);
	localparam logic [2:0] PERSIST_LAST = 3'(`OFDR_PERSIST_WIN - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode, used for both reads and writes.

	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offset);
		addr_hit = (addr == offset);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	ofdr_state_t s;
	ofdr_state_t next_s;

	logic unlocked;
	logic enabled;
	logic run_ok;
	logic osc_rise;
	logic out_of_range;

	always_comb begin
		next_s = s;
		next_s.rdata = `OFDR_READ_IDLE;
		next_s.osc_prev = osc_input_pin;

		unlocked = (s.detect_write_unlock == `OFDR_UNLOCK_OPEN);
		enabled = (s.detect_enable_control == `OFDR_CTRL_ON);
		// Internal resets keep the detector running so a bad clock cannot hide behind them.
		run_ok = mode.internal_reset | mode.normal | mode.idle;
		// Stop and its warm-up suspend detection; it resumes by itself afterwards.
		if (mode.stop || mode.warmup) begin
			run_ok = 1'b0;
		end
		if (mode.serial_prog) begin
			run_ok = 1'b0;
		end
		osc_rise = osc_input_pin & ~s.osc_prev;
		out_of_range = (s.edge_cnt < s.lower_freq_limit) || (s.edge_cnt > s.upper_freq_limit);

		// Register writes.
		if (bus.wr) begin
			if (addr_hit(bus.addr, `OFDR_ADDR_UNLOCK)) begin
				// Any code other than the open value relocks.
				if (bus.wdata == `OFDR_UNLOCK_OPEN) begin
					next_s.detect_write_unlock = `OFDR_UNLOCK_OPEN;
				end else begin
					next_s.detect_write_unlock = `OFDR_UNLOCK_SHUT;
				end
			end
			if (addr_hit(bus.addr, `OFDR_ADDR_CTRL) && unlocked) begin
				if (bus.wdata == `OFDR_CTRL_ON || bus.wdata == `OFDR_CTRL_OFF) begin
					next_s.detect_enable_control = bus.wdata;
				end
			end
			// Limits move only while unlocked and disabled, so the comparison never sees a torn pair.
			if (unlocked && !enabled) begin
				if (addr_hit(bus.addr, `OFDR_ADDR_LOWER)) begin
					next_s.lower_freq_limit = bus.wdata;
				end
				if (addr_hit(bus.addr, `OFDR_ADDR_UPPER)) begin
					next_s.upper_freq_limit = bus.wdata;
				end
			end
		end

		// Register reads; contents are shown whatever the unlock state.
		if (bus.rd) begin
			if (addr_hit(bus.addr, `OFDR_ADDR_UNLOCK)) begin
				next_s.rdata = s.detect_write_unlock;
			end else if (addr_hit(bus.addr, `OFDR_ADDR_CTRL)) begin
				next_s.rdata = s.detect_enable_control;
			end else if (addr_hit(bus.addr, `OFDR_ADDR_LOWER)) begin
				next_s.rdata = s.lower_freq_limit;
			end else if (addr_hit(bus.addr, `OFDR_ADDR_UPPER)) begin
				next_s.rdata = s.upper_freq_limit;
			end else begin
				next_s.rdata = `OFDR_READ_IDLE;
			end
		end

		// Measurement.
		next_s.active = enabled && run_ok;
		case (s.phase)
			PH_OFF: begin
				next_s.win_cnt = '0;
				next_s.edge_cnt = '0;
				next_s.bad_cnt = '0;
				next_s.good_cnt = '0;
				next_s.det_rst = 1'b0;
				if (enabled && run_ok) begin
					next_s.phase = PH_WATCH;
				end
			end
			PH_WATCH, PH_FAULT: begin
				if (osc_rise && s.edge_cnt != `OFDR_EDGE_MAX) begin
					next_s.edge_cnt = s.edge_cnt + 8'h01;
				end
				next_s.win_cnt = s.win_cnt + 10'h001;
				if (s.win_cnt == WIN_LAST) begin
					next_s.win_cnt = '0;
					next_s.edge_cnt = '0;
					// A stopped oscillator counts zero edges and so reads as too slow.
					if (out_of_range) begin
						next_s.good_cnt = '0;
						if (s.phase == PH_WATCH) begin
							if (s.bad_cnt == PERSIST_LAST) begin
								next_s.bad_cnt = '0;
								next_s.det_rst = 1'b1;
								next_s.phase = PH_FAULT;
							end else begin
								next_s.bad_cnt = s.bad_cnt + 3'h1;
							end
						end
					end else begin
						next_s.bad_cnt = '0;
						if (s.phase == PH_FAULT) begin
							if (s.good_cnt == PERSIST_LAST) begin
								next_s.good_cnt = '0;
								next_s.det_rst = 1'b0;
								next_s.phase = PH_WATCH;
							end else begin
								next_s.good_cnt = s.good_cnt + 3'h1;
							end
						end
					end
				end
				// Leaving the allowed modes drops everything, including a pending reset.
				if (!(enabled && run_ok)) begin
					next_s.phase = PH_OFF;
					next_s.det_rst = 1'b0;
				end
			end
			default: begin
				next_s.phase = PH_OFF;
				next_s.det_rst = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Only the external reset reaches these flops; internal resets never clear them.

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s.detect_write_unlock <= `OFDR_UNLOCK_SHUT;
			s.detect_enable_control <= `OFDR_CTRL_OFF;
			s.lower_freq_limit <= `OFDR_LOWER_RST;
			s.upper_freq_limit <= `OFDR_UPPER_RST;
			s.rdata <= `OFDR_READ_IDLE;
			s.osc_prev <= 1'b0;
			s.win_cnt <= '0;
			s.edge_cnt <= '0;
			s.bad_cnt <= '0;
			s.good_cnt <= '0;
			s.det_rst <= 1'b0;
			s.active <= 1'b0;
			s.phase <= PH_OFF;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops.

	assign rdata = s.rdata;
	assign detect_reset = s.det_rst;
	// The pad ring exempts supply, reset and oscillator pins from this request.
	assign io_hiz_req = s.det_rst;
	assign detect_active = s.active;

endmodule // ofdr_top

// >>> tb/ofdr_osc_model.sv
// Behavioural oscillator watched by the frequency detector.
module ofdr_osc_model (
	input wire logic run,
	input wire logic [7:0] half_ns,
	output logic osc_input_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// A stopped crystal rests low rather than freezing at its last level.
	initial begin
		osc_input_pin = 1'b0;
		forever begin
			if (run) begin
				#(half_ns) osc_input_pin = ~osc_input_pin;
			end else begin
				#1 osc_input_pin = 1'b0;
			end
		end
	end
endmodule // ofdr_osc_model

// >>> tb/ofdr_top_sva.sv
// Port checks of the frequency detector.
`include "ofdr_map.svh"
module ofdr_top_sva
	import ofdr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire ofdr_pkg::ofdr_bus_t bus,
	input wire ofdr_pkg::ofdr_mode_t mode,
	input wire logic [7:0] rdata,
	input wire logic detect_reset,
	input wire logic io_hiz_req,
	input wire logic detect_active
);
	logic ok;
	logic ctl_rd;
	assign ok = (mode.normal | mode.idle | mode.internal_reset) & ~(mode.stop | mode.warmup | mode.serial_prog);
	assign ctl_rd = bus.rd && bus.addr == `OFDR_ADDR_CTRL;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_HIZ: assert property (io_hiz_req == detect_reset) else $error("hiz differs");
	AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("stray rdata");
	AST_STOP: assert property ($past(mode.stop) || $past(mode.warmup) |-> !detect_active) else $error("stop");
	AST_GATE: assert property (!$past(ok) |-> !detect_active && !detect_reset) else $error("gate");
	AST_TRIP: assert property ($rose(detect_reset) |-> detect_active && $past(detect_active, 8)) else $error("trip");
	AST_QUIET: assert property ($rose(detect_active) |-> !detect_reset [*8]) else $error("early trip");
	AST_EN_ON: assert property (ctl_rd && ok ##1 rdata == `OFDR_CTRL_ON |-> detect_active) else $error("on");
	AST_EN_OFF: assert property (ctl_rd ##1 rdata == `OFDR_CTRL_OFF |-> !detect_active) else $error("off");
endmodule // ofdr_top_sva
bind ofdr_top ofdr_top_sva u_ofdr_top_sva (.core_clk(core_clk), .reset_n(reset_n), .bus(bus), .mode(mode),
	.rdata(rdata), .detect_reset(detect_reset), .io_hiz_req(io_hiz_req), .detect_active(detect_active));

// >>> tb/ofdr_top_bench.sv
// Self-checking bench of the frequency detector.
`include "ofdr_map.svh"
module ofdr_top_bench
	import ofdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] ua = `OFDR_ADDR_UNLOCK;
	localparam logic [15:0] ca = `OFDR_ADDR_CTRL;
	localparam logic [15:0] la = `OFDR_ADDR_LOWER;
	logic core_clk, reset_n, osc_input_pin, detect_reset, io_hiz_req, detect_active, run;
	logic [7:0] rdata, half_ns;
	ofdr_bus_t bus;
	ofdr_mode_t mode;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	ofdr_top u_ofdr_top (.core_clk(core_clk), .reset_n(reset_n), .bus(bus), .mode(mode), .osc_input_pin(osc_input_pin),
		.rdata(rdata), .detect_reset(detect_reset), .io_hiz_req(io_hiz_req), .detect_active(detect_active));
	ofdr_osc_model u_ofdr_osc_model (.run(run), .half_ns(half_ns), .osc_input_pin(osc_input_pin));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// The longest scenario needs about 17000 cycles.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge core_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] exp);
		@(posedge core_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic wait_rst(logic exp, int lim);
		repeat (lim) begin
			@(posedge core_clk);
			#1;
			if (detect_reset === exp) break;
		end
		chk({7'h00, detect_reset}, {7'h00, exp});
	endtask
	task automatic set_mode(logic [5:0] m, logic exp);
		@(posedge core_clk);
		mode <= m;
		repeat (3) @(posedge core_clk);
		#1 chk({7'h00, detect_active}, {7'h00, exp});
	endtask
	task automatic t_reset_vals();
		rd(ua, 8'h06);
		rd(ca, 8'h00);
		rd(la, 8'h20);
		rd(`OFDR_ADDR_UPPER, 8'h40);
		rd(16'h1F80, 8'h00);
	endtask
	task automatic t_program();
		wr(ca, 8'hE4);
		wr(la, 8'h11);
		rd(ca, 8'h00);
		rd(la, 8'h20);
		wr(ua, 8'hF9);
		wr(la, 8'h18);
		wr(`OFDR_ADDR_UPPER, 8'h38);
		wr(ca, 8'hE4);
		wr(la, 8'h11);
		wr(ua, 8'h06);
		wr(ca, 8'h00);
		rd(ca, 8'hE4);
		rd(la, 8'h18);
	endtask
	task automatic t_faults();
		// An in-range oscillator must never trip the detector.
		@(posedge core_clk);
		run <= 1'b1;
		repeat (4000) @(posedge core_clk);
		#1 chk({7'h00, detect_reset}, 8'h00);
		@(posedge core_clk);
		run <= 1'b0;
		repeat (2300) @(posedge core_clk);
		#1 chk({7'h00, detect_reset}, 8'h00);
		wait_rst(1'b1, 2500);
		chk({7'h00, io_hiz_req}, 8'h01);
		@(posedge core_clk);
		mode <= 6'h01;
		repeat (10) @(posedge core_clk);
		#1 chk({6'h00, detect_active, detect_reset}, 8'h03);
		rd(la, 8'h18);
		rd(ca, 8'hE4);
		@(posedge core_clk);
		run <= 1'b1;
		wait_rst(1'b0, 5000);
		chk({7'h00, io_hiz_req}, 8'h00);
		@(posedge core_clk);
		half_ns <= 8'h14;
		wait_rst(1'b1, 5000);
		@(posedge core_clk);
		half_ns <= 8'h32;
		wait_rst(1'b0, 5000);
	endtask
	task automatic t_modes();
		set_mode(6'h28, 1'b0);
		set_mode(6'h24, 1'b0);
		set_mode(6'h20, 1'b1);
		set_mode(6'h22, 1'b0);
		set_mode(6'h00, 1'b0);
		set_mode(6'h10, 1'b1);
		wr(ua, 8'hF9);
		wr(ca, 8'h00);
		rd(ca, 8'h00);
	endtask
	task automatic t_ext_reset();
		wr(ca, 8'hE4);
		set_mode(6'h20, 1'b1);
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk({7'h00, detect_active}, 8'h00);
		@(posedge core_clk);
		reset_n <= 1'b1;
		t_reset_vals();
	endtask
	initial begin
		reset_n = 1'b0;
		bus = '0;
		mode = 6'h20;
		run = 1'b0;
		half_ns = 8'h32;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset_vals();
		t_program();
		t_faults();
		t_modes();
		t_ext_reset();
		summarize();
	end
endmodule // ofdr_top_bench
